/* rtl/mad_top.sv */
// Monitor selection, energy and hour meters and meter output of the drive.
// Assumes drive values come from same-clock logic; keys and output stop are pins.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
// Contract
// - Code 100: set freq stopped, output running
// - Stop value is limited and jump-adjusted frequency
// - Fault shows frequency captured at fault
// - Output stop displays like stop
// - Code 55: terminal segments, centre always lit
// - Hold set key 1s sets first monitor
// - Code 0: set key steps monitors
// - Energy integrates output power, hourly update
// - Panel energy four digits, shifting resolution
// - Unit energy five digits, resolution 0.1 above 999.99
// - Link reports kWh and 0.01 kWh
// - Digit shift applies to display and link
// - Shift 0-4 clamps; 9999 wraps
// - Writing 0 clears energy meter
// - Clear register reads 9999 or 10
// - Power-on hours count hourly
// - Run hours count only while running
// - Hours wrap past 65535, overflow counted
// - Run hours clearable; power-on hours not
// - Run clear reads 9999; 9999 write ignored
// - Run hours need a continuous hour
// - Meter output linear to full-scale reference
module mad_top #(
  parameter longint HOUR_CYCLES = mad_pkg::HOUR_CYC,
  parameter longint HOLD_CYCLES = mad_pkg::HOLD_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Drive values from same-clock logic, 0.01 Hz, 0.01 A, 0.1 V, 0.01 kW.
  input wire mad_pkg::mad_stat_t drive_stat,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] freq_max,
  input wire logic [15:0] freq_min,
  input wire logic [15:0] jump_lo,
  input wire logic [15:0] jump_hi,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_curr,
  input wire logic [15:0] out_volt,
  input wire logic [15:0] out_power,
  input wire logic [15:0] fault_code,
  input wire logic [6:0] in_terms,
  input wire logic [6:0] out_terms,
  input wire logic meter_is_current,
  // Pins.
  input wire logic set_key,
  input wire logic output_stop_input,
  // Display side.
  output logic [15:0] disp_value,
  output logic disp_hz_led,
  output logic [14:0] disp_segments,
  output logic [1:0] disp_dots,
  output logic [31:0] pu_value,
  output logic [11:0] analog_meter_output
);
  // Pin synchronisers. Key and output stop arrive from the panel with no clock relation;
  // only the second stage of each pair is read by the logic below.
  logic [1:0] key_s_q, mrs_s_q;
  logic key_prev_q;
  always_ff @(posedge clk) begin
    key_s_q <= {key_s_q[0], set_key};
    mrs_s_q <= {mrs_s_q[0], output_stop_input};
  end
  wire logic key = key_s_q[1];
  wire logic stopped = ~drive_stat.running | mrs_s_q[1] | drive_stat.out_stop;

  // Parameter registers.
  logic [15:0] mon_sel_q, shift_q, dec_sel_q, freq_fs_q, curr_fs_q, pwr_clr_rd_q;
  logic [15:0] pon_ovf_q, run_ovf_q, pon_hrs_q, run_hrs_q;
  logic [31:0] energy_q;
  logic [63:0] acc_q;
  wire logic wr_pclr = reg_wr && reg_addr == mad_pkg::ADDR_PWR_CLR && reg_wdata[15:0] == '0;
  wire logic wr_rclr = reg_wr && reg_addr == mad_pkg::ADDR_RUN_CLR && reg_wdata[15:0] == '0;

  // Software-written setup.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mon_sel_q <= mad_pkg::SEL_STEP;
      shift_q <= mad_pkg::CODE_OFF;
      dec_sel_q <= mad_pkg::CODE_OFF;
      freq_fs_q <= mad_pkg::FREQ_FS_RST;
      curr_fs_q <= mad_pkg::CURR_FS_RST;
      pwr_clr_rd_q <= mad_pkg::CODE_OFF;
    end else if (reg_wr) begin
      case (reg_addr)
        mad_pkg::ADDR_MON_SEL: mon_sel_q <= reg_wdata[15:0];
        mad_pkg::ADDR_DIG_SHIFT: shift_q <= reg_wdata[15:0];
        mad_pkg::ADDR_DEC_SEL: dec_sel_q <= reg_wdata[15:0];
        mad_pkg::ADDR_FREQ_FS: freq_fs_q <= reg_wdata[15:0];
        mad_pkg::ADDR_CURR_FS: curr_fs_q <= reg_wdata[15:0];
        // Readback after clear tells the link range: 10 keeps 9999 kWh, else 9999.
        mad_pkg::ADDR_PWR_CLR: if (reg_wdata[15:0] == '0) begin
          pwr_clr_rd_q <= (shift_q == mad_pkg::CODE_OFF) ? mad_pkg::CODE_OFF
                          : mad_pkg::CLR_READBACK_ALT;
        end
        default: ;
      endcase
    end
  end

  // Hour prescaler; power-on hours and energy move only on this tick, never with display refresh.
  // A 64-bit count covers a full hour at the system clock with room to spare.
  logic [63:0] hr_cnt_q;
  wire logic hour_tick = hr_cnt_q == HOUR_CYCLES - 1;
  always_ff @(posedge clk) begin
    if (sys_rst || hour_tick) hr_cnt_q <= '0;
    else hr_cnt_q <= hr_cnt_q + 64'h1;
  end

  // Power-on hours: no write reaches them.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pon_hrs_q <= '0;
      pon_ovf_q <= '0;
    end else if (hour_tick) begin
      pon_hrs_q <= pon_hrs_q + 16'h1;
      if (pon_hrs_q == mad_pkg::HOURS_MAX) pon_ovf_q <= pon_ovf_q + 16'h1;
    end
  end

  // Run hours: a private timer restarts on every stop, so short runs never count.
  logic [63:0] run_cnt_q;
  wire logic run_hour = !stopped && run_cnt_q == HOUR_CYCLES - 1;
  always_ff @(posedge clk) begin
    if (sys_rst || stopped || run_hour) run_cnt_q <= '0;
    else run_cnt_q <= run_cnt_q + 64'h1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_hrs_q <= '0;
      run_ovf_q <= '0;
    end else if (wr_rclr) begin
      run_hrs_q <= '0;
    end else if (run_hour) begin
      run_hrs_q <= run_hrs_q + 16'h1;
      if (run_hrs_q == mad_pkg::HOURS_MAX) run_ovf_q <= run_ovf_q + 16'h1;
    end
  end

  // Energy: power (0.01 kW) is summed each cycle; one hour of sum is 0.01 kWh units.
  // The remainder of each hour's sum is dropped, so the error stays under 0.01 kWh an hour.
  logic [31:0] e_next;
  always_comb begin
    e_next = energy_q + 32'(acc_q / 64'(HOUR_CYCLES));
    if (e_next > mad_pkg::PU_MAX) begin
      e_next = (shift_q == mad_pkg::CODE_OFF) ? e_next - mad_pkg::PU_MAX - 32'h1
               : mad_pkg::PU_MAX;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst || wr_pclr) begin
      energy_q <= '0;
      acc_q <= '0;
    end else if (hour_tick) begin
      energy_q <= e_next;
      acc_q <= 64'(out_power);
    end else begin
      acc_q <= acc_q + 64'(out_power);
    end
  end

  // Digit shift and link values. The shift counts decimal digits, so the divisor is
  // ten to the power of the setting; settings above nine, the off code included,
  // leave the total unshifted. Nine digits is the most a 32-bit divisor can hold.
  logic [31:0] e_shift, e_kwh, dig_div;
  always_comb begin
    dig_div = 32'h1;
    // One factor of ten for each digit the setting asks for.
    for (int i = 0; i < 9; i++) begin
      if (shift_q <= 16'h9 && 16'(i) < shift_q) dig_div = dig_div * 32'ha;
    end
    e_shift = energy_q / dig_div;
    // The link also sends whole kilowatt-hours of the shifted total.
    e_kwh = e_shift / 32'h64;
  end

  // First monitor and set key walk.
  logic [31:0] hold_q;
  mad_pkg::mad_mon_t mon_q, first_q;
  always_ff @(posedge clk) begin
    key_prev_q <= key;
    if (sys_rst || !key) hold_q <= '0;
    else if (hold_q != HOLD_CYCLES) hold_q <= hold_q + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mon_q <= mad_pkg::MAD_MON_FREQ;
      first_q <= mad_pkg::MAD_MON_FREQ;
    end else begin
      if (key && hold_q == HOLD_CYCLES - 1) first_q <= mon_q;
      if (key && !key_prev_q && mon_sel_q == mad_pkg::SEL_STEP) begin
        mon_q <= mad_pkg::mad_mon_t'(mon_q + 2'd1);
      end
    end
  end

  // Frequency that a start would produce: limits then jump band.
  logic [15:0] lim_freq;
  always_comb begin
    lim_freq = set_freq;
    if (lim_freq > freq_max) lim_freq = freq_max;
    if (lim_freq < freq_min) lim_freq = freq_min;
    if (lim_freq > jump_lo && lim_freq < jump_hi) lim_freq = jump_lo;
  end

  // Output frequency is frozen on the rising edge of a fault.
  logic [15:0] fault_freq_q;
  logic fault_prev_q;
  always_ff @(posedge clk) begin
    fault_prev_q <= drive_stat.fault;
    if (drive_stat.fault && !fault_prev_q) fault_freq_q <= out_freq;
  end
  // In the first fault cycle the capture register still holds an older value, so the
  // live frequency is shown for that one cycle; it is the value being captured anyway.
  wire logic [15:0] freq_shown = (drive_stat.fault && fault_prev_q) ? fault_freq_q : out_freq;

  // Decimal digit select on a value with two decimals.
  function automatic logic [15:0] dec_fix(input logic [15:0] v, input logic [15:0] sel);
    logic [15:0] r;
    r = v;
    // Setting 0 cuts the fraction away, so any value under one unit reads as zero.
    // Rounding up instead would show 0.50 to 0.99 as one, which the setting forbids.
    if (sel == 16'h0) r = v / 16'h64 * 16'h64;
    else if (sel == 16'd1) r = v / 16'd10 * 16'd10;
    return r;
  endfunction

  // Display composition.
  logic [15:0] disp_d;
  logic [31:0] pu_d;
  logic [1:0] dots_d;
  logic hz_d;
  always_comb begin
    disp_d = '0;
    dots_d = 2'd2;
    hz_d = 1'b0;
    pu_d = e_shift;
    case (mon_sel_q)
      mad_pkg::SEL_STOP_SET: begin
        disp_d = (stopped && !drive_stat.fault) ? lim_freq : freq_shown;
        hz_d = stopped ? hr_cnt_q[24] : 1'b1;
      end
      mad_pkg::SEL_ENERGY: begin
        // Panel carries four digits: dot moves as the total grows.
        if (e_shift <= mad_pkg::PANEL_DOT1) begin
          disp_d = e_shift[15:0];
        end else if (e_shift <= mad_pkg::PANEL_DOT0) begin
          disp_d = 16'(e_shift / 32'd10);
          dots_d = 2'd1;
        end else begin
          disp_d = 16'(((e_shift > mad_pkg::PANEL_MAX) ? mad_pkg::PANEL_MAX : e_shift) / 32'd100);
          dots_d = 2'd0;
        end
        // Unit carries five digits.
        pu_d = (e_shift > mad_pkg::PU_DOT1) ? e_shift / 32'd10 : e_shift;
      end
      mad_pkg::SEL_PON: begin
        disp_d = pon_hrs_q;
        dots_d = 2'd0;
      end
      mad_pkg::SEL_RUN: begin
        disp_d = run_hrs_q;
        dots_d = 2'd0;
      end
      default: begin
        case (mon_q)
          mad_pkg::MAD_MON_FREQ: begin
            disp_d = dec_fix(freq_shown, dec_sel_q);
            hz_d = 1'b1;
          end
          mad_pkg::MAD_MON_CURR: disp_d = dec_fix(out_curr, dec_sel_q);
          mad_pkg::MAD_MON_VOLT: disp_d = out_volt;
          default: disp_d = fault_code;
        endcase
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      disp_value <= '0;
      disp_dots <= '0;
      disp_hz_led <= 1'b0;
      pu_value <= '0;
      disp_segments <= '0;
    end else begin
      disp_value <= disp_d;
      disp_dots <= dots_d;
      disp_hz_led <= hz_d;
      pu_value <= pu_d;
      disp_segments <= (mon_sel_q == mad_pkg::SEL_IO_MON)
                       ? {in_terms, 1'b1, out_terms} : '0;
    end
  end

  // Meter output, clamped at the full-scale reference.
  // A zero full-scale setting would divide by zero, so it pins the output at full scale.
  logic [27:0] a_num;
  logic [15:0] a_fs, a_val;
  always_comb begin
    a_val = meter_is_current ? out_curr : freq_shown;
    a_fs = meter_is_current ? curr_fs_q : freq_fs_q;
    a_num = 28'(a_val) * 28'(mad_pkg::AOUT_MAX);
  end
  always_ff @(posedge clk) begin
    if (sys_rst) analog_meter_output <= '0;
    else if (a_fs == '0 || a_val >= a_fs) analog_meter_output <= mad_pkg::AOUT_MAX;
    else analog_meter_output <= 12'(a_num / 28'(a_fs));
  end

  // Read port: data one cycle after the strobe, zero elsewhere.
  // Holding zero outside the read slot lets a shared read bus simply OR its slaves.
  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        mad_pkg::ADDR_MON_SEL: reg_rdata <= {16'h0, mon_sel_q};
        mad_pkg::ADDR_PWR_CLR: reg_rdata <= {16'h0, pwr_clr_rd_q};
        mad_pkg::ADDR_RUN_CLR: reg_rdata <= {16'h0, mad_pkg::CODE_OFF};
        mad_pkg::ADDR_DIG_SHIFT: reg_rdata <= {16'h0, shift_q};
        mad_pkg::ADDR_DEC_SEL: reg_rdata <= {16'h0, dec_sel_q};
        mad_pkg::ADDR_PON_OVF: reg_rdata <= {16'h0, pon_ovf_q};
        mad_pkg::ADDR_RUN_OVF: reg_rdata <= {16'h0, run_ovf_q};
        mad_pkg::ADDR_FREQ_FS: reg_rdata <= {16'h0, freq_fs_q};
        mad_pkg::ADDR_CURR_FS: reg_rdata <= {16'h0, curr_fs_q};
        mad_pkg::ADDR_PON_HRS: reg_rdata <= {16'h0, pon_hrs_q};
        mad_pkg::ADDR_RUN_HRS: reg_rdata <= {16'h0, run_hrs_q};
        mad_pkg::ADDR_ENERGY: reg_rdata <= e_shift;
        mad_pkg::ADDR_ENERGY_KWH: reg_rdata <= e_kwh;
        mad_pkg::ADDR_FIRST_MON: reg_rdata <= {30'h0, first_q};
        default: reg_rdata <= '0;
      endcase
    end
  end
endmodule // mad_top

/* pkg/mad_pkg.sv */
// Package for the monitor, meter and display block of the drive.
// Assumes one 100 MHz clock and a plain address/strobe register port.
package mad_pkg;
  // Register offsets (byte addresses, one word each).
  localparam logic [7:0] ADDR_MON_SEL = 8'h00;
  localparam logic [7:0] ADDR_PWR_CLR = 8'h04;
  localparam logic [7:0] ADDR_RUN_CLR = 8'h08;
  localparam logic [7:0] ADDR_DIG_SHIFT = 8'h0c;
  localparam logic [7:0] ADDR_DEC_SEL = 8'h10;
  localparam logic [7:0] ADDR_PON_OVF = 8'h14;
  localparam logic [7:0] ADDR_RUN_OVF = 8'h18;
  localparam logic [7:0] ADDR_FREQ_FS = 8'h1c;
  localparam logic [7:0] ADDR_CURR_FS = 8'h20;
  localparam logic [7:0] ADDR_PON_HRS = 8'h24;
  localparam logic [7:0] ADDR_RUN_HRS = 8'h28;
  localparam logic [7:0] ADDR_ENERGY = 8'h2c;
  localparam logic [7:0] ADDR_ENERGY_KWH = 8'h30;
  localparam logic [7:0] ADDR_FIRST_MON = 8'h34;
  // Parameter codes and reset values.
  localparam logic [15:0] SEL_STOP_SET = 16'h0064;
  localparam logic [15:0] SEL_IO_MON = 16'h0037;
  localparam logic [15:0] SEL_STEP = 16'h0000;
  localparam logic [15:0] SEL_ENERGY = 16'h0019;
  localparam logic [15:0] SEL_PON = 16'h0014;
  localparam logic [15:0] SEL_RUN = 16'h0017;
  localparam logic [15:0] CODE_OFF = 16'h270f;
  localparam logic [15:0] CLR_READBACK_ALT = 16'h000a;
  localparam logic [15:0] FREQ_FS_RST = 16'h1770;
  localparam logic [15:0] CURR_FS_RST = 16'h03e8;
  localparam logic [15:0] HOURS_MAX = 16'hffff;
  // Energy limits in 0.01 kWh.
  localparam logic [31:0] PANEL_MAX = 32'h000f_423f;
  localparam logic [31:0] PU_MAX = 32'h0098_967f;
  localparam logic [31:0] PANEL_DOT1 = 32'h0000_270f;
  localparam logic [31:0] PANEL_DOT0 = 32'h0001_869f;
  localparam logic [31:0] PU_DOT1 = 32'h0001_869f;
  // Timing in its own units and derived cycle counts.
  localparam int CLK_HZ = 100_000_000;
  localparam int HOLD_MS = 1000;
  localparam longint HOLD_CYC = longint'(CLK_HZ) * HOLD_MS / 1000;
  localparam int HOUR_S = 3600;
  localparam longint HOUR_CYC = longint'(CLK_HZ) * HOUR_S;
  localparam logic [11:0] AOUT_MAX = 12'hfff;
  // Display steps for the set key walk.
  typedef enum logic [1:0] {MAD_MON_FREQ, MAD_MON_CURR, MAD_MON_VOLT, MAD_MON_FAULT} mad_mon_t;
  // Drive status carried together.
  typedef struct packed {
    logic running;
    logic fault;
    logic out_stop;
  } mad_stat_t;
endpackage

/* verification/mad_panel_model.sv */
// Panel-side model: the key and the output stop pin seen by the block.
// Assumes the bench asks for presses on its own clock.
`timescale 1ns/1ns
module mad_panel_model #(
  parameter int PRESS_CYC = 2
) (
  // Clock.
  input wire logic clk,
  // Requests from the bench.
  input wire logic press_go,
  input wire logic stop_req,
  // Pins toward the block.
  output logic set_key,
  output logic output_stop_input
);
  // Cycles left in the current press; short presses stay under the hold time.
  int cnt_q = 0;
  // A press is held while press_go is high and PRESS_CYC cycles after, as a finger would hold it.
  always_ff @(posedge clk) begin
    if (press_go) begin
      cnt_q <= PRESS_CYC;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign set_key = (cnt_q > 0);
  assign output_stop_input = stop_req;
endmodule // mad_panel_model

/* verification/mad_top_assertions.sv */
// Checker for the register port and the frequency display of the block.
// Assumes it is bound to mad_top and sees only its ports.
`timescale 1ns/1ns
module mad_checker (
  // Clock, reset and register port.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Drive values and pins.
  input wire mad_pkg::mad_stat_t drive_stat,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] freq_max,
  input wire logic [15:0] freq_min,
  input wire logic [15:0] jump_lo,
  input wire logic [15:0] jump_hi,
  input wire logic [15:0] out_freq,
  input wire logic [6:0] in_terms,
  input wire logic [6:0] out_terms,
  input wire logic output_stop_input,
  // Display outputs.
  input wire logic [15:0] disp_value,
  input wire logic disp_hz_led,
  input wire logic [14:0] disp_segments
);
  // Shadow of the monitor selection, tracked from port writes.
  logic [15:0] sel_q;
  logic [79:0] fin;
  assign fin = {set_freq, freq_max, freq_min, jump_lo, jump_hi};
  // The shadow follows the same write timing as the block's own register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_q <= 16'h0000;
    end else if (reg_wr && reg_addr == mad_pkg::ADDR_MON_SEL) begin
      sel_q <= reg_wdata[15:0];
    end
  end
  // Frequency that a start would give: limits first, then the jump band.
  function automatic logic [15:0] lim(input logic [79:0] f);
    logic [15:0] x;
    x = (f[79:64] > f[63:48]) ? f[63:48] : f[79:64];
    x = (x < f[47:32]) ? f[47:32] : x;
    return (x > f[31:16] && x < f[15:0]) ? f[31:16] : x;
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_run;
    sel_q == mad_pkg::SEL_STOP_SET && drive_stat == 3'b100 && !output_stop_input
      && $stable(out_freq);
  endsequence
  sequence s_stop;
    sel_q == mad_pkg::SEL_STOP_SET && drive_stat == 3'b000 && $stable(fin);
  endsequence
  sequence s_mrs;
    sel_q == mad_pkg::SEL_STOP_SET && drive_stat == 3'b100 && output_stop_input
      && $stable(fin);
  endsequence
  property p_run_val;
    s_run [*4] |-> disp_value == out_freq;
  endproperty
  a_run_val: assert property (p_run_val) else $error("running display differs");
  property p_hz_run;
    s_run [*4] |-> disp_hz_led;
  endproperty
  a_hz_run: assert property (p_hz_run) else $error("hz led not lit while running");
  property p_stop_val;
    s_stop [*4] |-> disp_value == lim(fin);
  endproperty
  a_stop_val: assert property (p_stop_val) else $error("stop display differs");
  property p_mrs_val;
    s_mrs [*6] |-> disp_value == lim(fin);
  endproperty
  a_mrs_val: assert property (p_mrs_val) else $error("output stop display differs");
  property p_io_seg;
    sel_q == mad_pkg::SEL_IO_MON && $past(sel_q) == mad_pkg::SEL_IO_MON
      && $stable({in_terms, out_terms}) |-> disp_segments == {in_terms, 1'b1, out_terms};
  endproperty
  a_io_seg: assert property (p_io_seg) else $error("terminal segments differ");
  property p_run_clr_rd;
    reg_rd && reg_addr == mad_pkg::ADDR_RUN_CLR |=> reg_rdata == 32'h0000_270f;
  endproperty
  a_run_clr_rd: assert property (p_run_clr_rd) else $error("run clear readback");
  property p_pwr_clr_rd;
    reg_rd && reg_addr == mad_pkg::ADDR_PWR_CLR |=> reg_rdata inside {32'h270f, 32'h000a};
  endproperty
  a_pwr_clr_rd: assert property (p_pwr_clr_rd) else $error("power clear readback");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule // mad_checker
bind mad_top mad_checker u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .drive_stat(drive_stat), .set_freq(set_freq), .freq_max(freq_max), .freq_min(freq_min),
  .jump_lo(jump_lo), .jump_hi(jump_hi), .out_freq(out_freq), .in_terms(in_terms),
  .out_terms(out_terms), .output_stop_input(output_stop_input), .disp_value(disp_value),
  .disp_hz_led(disp_hz_led), .disp_segments(disp_segments));

/* verification/tb_top.sv */
// Self-checking bench for mad_top with short hour and hold counts.
// Assumes the panel model drives the key and output stop pins.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] v, e;
  mad_pkg::mad_stat_t drive_stat = 3'b000;
  logic [15:0] set_freq = 16'h0bb8, freq_max = 16'h1770, freq_min = 16'h0000;
  logic [15:0] jump_lo = 16'h03e8, jump_hi = 16'h04b0, out_freq = 16'h0abc;
  logic [15:0] out_curr = 16'h0335, out_power = 16'h1388;
  logic [6:0] in_terms = 7'h55, out_terms = 7'h2a;
  logic press_go = 1'b0, stop_req = 1'b0, set_key, output_stop_input;
  logic [15:0] disp_value;
  logic disp_hz_led;
  logic [14:0] disp_segments;
  logic [1:0] disp_dots;
  logic [31:0] pu_value;
  logic [11:0] analog_meter_output;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  // Rows: set, max, min, jump low, jump high, then the frequency a start gives.
  logic [95:0] rows [5] = '{{16'h0bb8, 16'h1770, 16'h0000, 16'h03e8, 16'h04b0, 16'h0bb8},
    {16'h1b58, 16'h1770, 16'h0000, 16'h03e8, 16'h04b0, 16'h1770},
    {16'h0064, 16'h1770, 16'h01f4, 16'h03e8, 16'h04b0, 16'h01f4},
    {16'h044c, 16'h1770, 16'h0000, 16'h03e8, 16'h04b0, 16'h03e8},
    {16'h04b0, 16'h1770, 16'h0000, 16'h03e8, 16'h04b0, 16'h04b0}};
  // Reset readback: address and value.
  logic [39:0] rst_tab [6] = '{{8'h08, 32'h270f}, {8'h04, 32'h270f}, {8'h1c, 32'h1770},
    {8'h20, 32'h03e8}, {8'h00, 32'h0}, {8'hfc, 32'h0}};
  mad_top #(.HOUR_CYCLES(20), .HOLD_CYCLES(4)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .drive_stat(drive_stat), .set_freq(set_freq),
    .freq_max(freq_max), .freq_min(freq_min), .jump_lo(jump_lo), .jump_hi(jump_hi),
    .out_freq(out_freq), .out_curr(out_curr), .out_volt(16'h0dac), .out_power(out_power),
    .fault_code(16'h0000), .in_terms(in_terms), .out_terms(out_terms),
    .meter_is_current(1'b0), .set_key(set_key), .output_stop_input(output_stop_input),
    .disp_value(disp_value), .disp_hz_led(disp_hz_led), .disp_segments(disp_segments),
    .disp_dots(disp_dots), .pu_value(pu_value), .analog_meter_output(analog_meter_output));
  mad_panel_model u_panel (.clk(clk), .press_go(press_go), .stop_req(stop_req),
    .set_key(set_key), .output_stop_input(output_stop_input));
  initial forever #5 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One write cycle; the strobe drops on the next edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // One read cycle; data are taken in the single cycle where they stand.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    cyc(12);
    sys_rst <= 1'b0;
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][39:32], v);
      `CHK("reset value", rst_tab[i][31:0], v)
    end
    done("reset");
    cyc(4);
    `CHK("step freq", out_freq, disp_value)
    // 27.48 Hz against the 60 Hz reset reference: 2748 * 4095 / 6000 = 1875.
    `CHK("meter out", 12'h753, analog_meter_output)
    press_go <= 1'b1;
    cyc(1);
    press_go <= 1'b0;
    cyc(8);
    `CHK("step curr", out_curr, disp_value)
    // 8.21 A shows as 8.00 in whole units and as 8.20 without hundredths.
    wr(mad_pkg::ADDR_DEC_SEL, 32'h0);
    cyc(2);
    `CHK("whole units", 16'h0320, disp_value)
    wr(mad_pkg::ADDR_DEC_SEL, 32'h1);
    cyc(2);
    `CHK("drop hundredths", 16'h0334, disp_value)
    // A long press first steps to voltage, then makes it the first monitor.
    press_go <= 1'b1;
    cyc(8);
    press_go <= 1'b0;
    cyc(6);
    rd(mad_pkg::ADDR_FIRST_MON, v);
    `CHK("first monitor", 32'h2, v)
    done("key step");
    wr(mad_pkg::ADDR_MON_SEL, 32'h64);
    foreach (rows[i]) begin
      {set_freq, freq_max, freq_min, jump_lo, jump_hi} <= rows[i][95:16];
      cyc(5);
      `CHK("stop freq", rows[i][15:0], disp_value)
    end
    done("stop rows");
    drive_stat <= 3'b100;
    cyc(6);
    `CHK("run freq", 16'h0abc, disp_value)
    `CHK("hz led", 1'b1, disp_hz_led)
    stop_req <= 1'b1;
    cyc(8);
    `CHK("output stop", 16'h04b0, disp_value)
    stop_req <= 1'b0;
    cyc(6);
    drive_stat <= 3'b110;
    cyc(2);
    out_freq <= 16'h0123;
    cyc(6);
    `CHK("fault freq", 16'h0abc, disp_value)
    drive_stat <= 3'b000;
    done("run, stop pin, fault");
    wr(mad_pkg::ADDR_MON_SEL, 32'h37);
    cyc(4);
    `CHK("segments", {in_terms, 1'b1, out_terms}, disp_segments)
    done("terminals");
    wr(mad_pkg::ADDR_RUN_CLR, 32'h0);
    rd(mad_pkg::ADDR_RUN_HRS, v);
    `CHK("run cleared", 32'h0, v)
    drive_stat <= 3'b100;
    cyc(15);
    drive_stat <= 3'b000;
    cyc(30);
    rd(mad_pkg::ADDR_RUN_HRS, v);
    `CHK("short run", 32'h0, v)
    drive_stat <= 3'b100;
    cyc(45);
    drive_stat <= 3'b000;
    cyc(50);
    wr(mad_pkg::ADDR_RUN_CLR, 32'h270f);
    rd(mad_pkg::ADDR_RUN_HRS, v);
    `CHK("run hours", 32'h2, v)
    wr(mad_pkg::ADDR_PON_HRS, 32'h0);
    rd(mad_pkg::ADDR_PON_HRS, v);
    `CHK("power-on kept", 1'b1, v != 32'h0)
    done("hours");
    rd(mad_pkg::ADDR_ENERGY, v);
    `CHK("energy grows", 1'b1, v != 32'h0)
    out_power <= 16'h0000;
    cyc(45);
    // The total is frozen now; a two-digit shift divides it by one hundred everywhere.
    rd(mad_pkg::ADDR_ENERGY, v);
    wr(mad_pkg::ADDR_DIG_SHIFT, 32'h2);
    wr(mad_pkg::ADDR_MON_SEL, 32'h19);
    rd(mad_pkg::ADDR_ENERGY, e);
    `CHK("shifted energy", v / 32'h64, e)
    rd(mad_pkg::ADDR_ENERGY_KWH, e);
    `CHK("link kwh", v / 32'h2710, e)
    `CHK("panel energy", 16'(v / 32'h64), disp_value)
    `CHK("panel dots", 2'h2, disp_dots)
    `CHK("unit energy", v / 32'h64, pu_value)
    wr(mad_pkg::ADDR_PWR_CLR, 32'h0);
    rd(mad_pkg::ADDR_PWR_CLR, e);
    `CHK("clear readback shifted", 32'ha, e)
    wr(mad_pkg::ADDR_DIG_SHIFT, 32'h270f);
    wr(mad_pkg::ADDR_PWR_CLR, 32'h0);
    rd(mad_pkg::ADDR_ENERGY, v);
    `CHK("energy cleared", 32'h0, v)
    rd(mad_pkg::ADDR_PWR_CLR, v);
    `CHK("clear readback", 32'h270f, v)
    done("energy");
    end_of_test();
  end
endmodule // tb_top
